// File: sca_assertions.sv
// watches the converter readout from its top-level pins only
module sca_assertions (
   input wire logic i_ref_clk,            // block clock
   input wire logic i_rst,                // async reset, high
   input wire logic i_serial_clk,         // host serial clock
   input wire logic i_sample_trigger,     // convert strobe
   input wire logic o_serial_result_out,  // data level
   input wire logic o_serial_result_oe_n, // low drives
   input wire logic o_acquiring,          // acquisition open
   input wire logic o_nap,                // nap state
   input wire logic o_sleep               // sleep state
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   one_state_a: assert property (!(o_nap && o_sleep))
      else $error("nap and sleep both set");
   hiz_power_a: assert property ((o_nap || o_sleep) |-> o_serial_result_oe_n)
      else $error("output driven while powered down");
   sleep_wake_a: assert property (
      o_sleep && $rose(i_serial_clk) |-> ##[1:4] !o_sleep)
      else $error("sleep not left after serial clock");
   nap_wake_a: assert property (
      o_nap && $changed(i_serial_clk) |-> ##[1:4] !o_nap)
      else $error("nap not left after serial clock");
   acq_close_a: assert property (
      o_acquiring && $rose(i_sample_trigger) |-> ##[1:3] !o_acquiring)
      else $error("acquisition not closed by trigger");
   // a bit may only move while the serial clock is high after a rise
   data_hold_a: assert property ($changed(o_serial_result_out) &&
      !o_serial_result_oe_n && $past(!o_serial_result_oe_n)
      |-> i_serial_clk || $past(i_serial_clk))
      else $error("data moved without serial rise");
   frame_start_a: assert property ($fell(o_serial_result_oe_n)
      |-> !o_serial_result_out && (i_serial_clk || $past(i_serial_clk)))
      else $error("frame did not start with pad after rise");
   trig_idle_a: assert property (
      $rose(i_sample_trigger) |-> o_serial_result_oe_n)
      else $error("output still driven at new trigger");
   frame_c: cover property ($fell(o_serial_result_oe_n));
   nap_c: cover property ($rose(o_nap));
   sleep_c: cover property ($rose(o_sleep));
endmodule

// File: sca_buf.sv
// two-entry buffer; read data comes from a register
module sca_buf #(
   parameter int W = 14
) (
   input  wire logic i_ref_clk,   // clock
   input  wire logic i_rst,       // async reset, high
   sca_buf_if.snk    in_side,     // filling side
   sca_buf_if.src    out_side     // draining side
);
   logic [W-1:0] mem_reg [2];     // storage
   logic [1:0]   cnt_reg;         // entries held
   logic         wp_reg;          // write slot
   logic         rp_reg;          // read slot
   logic [W-1:0] rd_reg;          // registered head word
   wire          push = in_side.valid && in_side.ready;
   wire          pop  = out_side.valid && out_side.ready;
   // honest full and empty flags drive the handshakes
   assign in_side.ready  = (cnt_reg != 2'h2);
   assign out_side.valid = (cnt_reg != 2'h0);
   assign out_side.data  = rd_reg;
   // head register follows the read slot after each change
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_reg <= 2'h0;
         wp_reg  <= 1'b0;
         rp_reg  <= 1'b0;
      end else begin
         if (push) wp_reg <= ~wp_reg;
         if (pop)  rp_reg <= ~rp_reg;
         cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
      end
   end
   // storage writes and head selection
   always_ff @(posedge i_ref_clk) begin
      if (push) mem_reg[wp_reg] <= in_side.data;
      if (push && (cnt_reg == 2'h0 || (cnt_reg == 2'h1 && pop)))
         rd_reg <= in_side.data;
      else if (pop)
         rd_reg <= mem_reg[~rp_reg];
   end
endmodule

// File: sca_buf_if.sv
// word path between converter core and shifter
interface sca_buf_if #(parameter int W = 14);
   logic         valid;   // word offered
   logic         ready;   // word accepted
   logic [W-1:0] data;    // result word
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// File: sca_core.sv
// serial converter readout; the serial clock is sampled on i_ref_clk
module sca_core #(
   parameter int RES = 14                   // 14 or 12 bit variant
) (
   input  wire logic           i_ref_clk,         // block clock
   input  wire logic           i_rst,             // async reset, high
   input  wire logic           i_serial_clk,      // host serial clock
   input  wire logic           i_sample_trigger,  // convert strobe
   input  wire logic           i_late_trigger,    // trigger inside 3 ns
   input  wire logic [RES-1:0] i_sample_value,    // quantised input
   output logic                o_serial_result_out, // data level
   output logic                o_serial_result_oe_n, // low drives
   output logic                o_acquiring,       // acquisition open
   output logic                o_nap,             // nap state
   output logic                o_sleep            // sleep state
);
   // edge detection state
   logic sck_d_reg;                       // last serial clock
   logic trg_d_reg;                       // last trigger
   wire  sck_rise = i_serial_clk && !sck_d_reg;
   wire  sck_edge = i_serial_clk != sck_d_reg;
   wire  trg_rise = i_sample_trigger && !trg_d_reg;

   // conversion and readout
   logic [RES-1:0]   held_reg;            // frozen input
   logic             held_ok_reg;         // a sample is held
   logic [4:0]       cnt_reg;             // counted rises since trigger
   logic             delay_reg;           // late-trigger slip
   logic [15:0]      shift_reg;           // outgoing frame
   logic             drive_reg;           // output enabled
   logic             acq_reg;             // acquisition window
   logic [2:0]       pulses_reg;          // triggers with clock still
   sca_pkg::sca_pwr_type pwr_reg;         // power state

   sca_buf_if #(.W(RES)) cv ();           // conversion results
   sca_buf_if #(.W(RES)) rd ();           // to shifter

   sca_buf #(.W(RES)) u_buf (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .in_side   (cv),
      .out_side  (rd)
   );

   // the previous conversion's held value enters the buffer on trigger
   assign cv.valid = trg_rise && held_ok_reg;
   assign cv.data  = held_reg;
   // the shifter takes a word at the first counted rise after a trigger;
   // a later start would push the last bits past the frame's rises
   wire   frame_go = (cnt_reg == '0) && sck_rise && !delay_reg;
   assign rd.ready = frame_go;

   // padded frame: leading zeros then msb first, trailing zeros only when RES is below 14
   function automatic logic [15:0] frame_of(input logic [RES-1:0] w);
      frame_of = 16'(w) << (sca_pkg::FRAME_LEN - sca_pkg::LEAD_PAD - RES);
   endfunction

   // edge history
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         sck_d_reg <= 1'b0;
         trg_d_reg <= 1'b0;
      end else begin
         sck_d_reg <= i_serial_clk;
         trg_d_reg <= i_sample_trigger;
      end
   end

   // trigger freezes input, counter steps on each serial rise except the late-trigger slip rise, and parks at CNT_IDLE
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         held_reg    <= '0;
         held_ok_reg <= 1'b0;
         cnt_reg     <= sca_pkg::CNT_IDLE;
         delay_reg   <= 1'b0;
         acq_reg     <= 1'b0;
      end else if (trg_rise) begin
         held_reg    <= i_sample_value;
         held_ok_reg <= 1'b1;
         cnt_reg     <= 5'h0;
         delay_reg   <= i_late_trigger;
         acq_reg     <= 1'b0;
      end else if (sck_rise) begin
         if (delay_reg)
            delay_reg <= 1'b0;
         else if (cnt_reg != sca_pkg::CNT_IDLE) begin
            cnt_reg <= cnt_reg + 5'h1;
            if (cnt_reg == 5'(sca_pkg::ACQ_OPEN_EDGE - 1))
               acq_reg <= 1'b1;
         end
      end
   end

   // shifter: msb first, three-state outside frame
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         shift_reg <= '0;
         drive_reg <= 1'b0;
      end else if (frame_go) begin
         shift_reg <= rd.valid ? frame_of(rd.data) : '0;
         drive_reg <= rd.valid;
      end else if (sck_rise && drive_reg && !delay_reg) begin
         shift_reg <= {shift_reg[14:0], 1'b0};
         // the last bit must still stand at the rise that latches it
         if (cnt_reg == 5'(sca_pkg::LEAD_PAD + RES))
            drive_reg <= 1'b0;
      end
   end

   // power states from trigger pulses while clock is still
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         pulses_reg <= 3'h0;
         pwr_reg    <= sca_pkg::SCA_ACTIVE;
      end else if (sck_edge) begin
         pulses_reg <= 3'h0;
         pwr_reg    <= sca_pkg::SCA_ACTIVE;
      end else if (trg_rise) begin
         if (pulses_reg != 3'h7)
            pulses_reg <= pulses_reg + 3'h1;
         case (pulses_reg + 3'h1)
            3'(sca_pkg::NAP_PULSES):   pwr_reg <= sca_pkg::SCA_NAP;
            3'(sca_pkg::SLEEP_PULSES): pwr_reg <= sca_pkg::SCA_SLEEP;
            default:                   pwr_reg <= pwr_reg;
         endcase
      end
   end

   assign o_serial_result_out  = shift_reg[15];
   assign o_serial_result_oe_n = !drive_reg;
   assign o_acquiring          = acq_reg;
   assign o_nap                = (pwr_reg == sca_pkg::SCA_NAP);
   assign o_sleep              = (pwr_reg == sca_pkg::SCA_SLEEP);
endmodule

// File: sca_core_bench.sv
module sca_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_ref_clk = 1'b0;        // block clock
   logic        i_rst = 1'b1;            // reset, high
   logic        i_late_trigger = 1'b0;   // late trigger flag
   logic [13:0] i_sample_value = 14'h0000; // quantised input
   wire         ser_clk, trig, sro, sro_oe_n, acq, nap, slp; // dut pins
   logic [15:0] exp_q[$];                // expected frames, oldest first
   logic [15:0] sh = 16'h0000;           // bits caught this frame
   logic        ser_last = 1'b0;         // serial clock at last look
   logic [13:0] prev = 14'h0000;         // value held at last trigger
   int          failures = 0, tests_run = 0, cycles = 0;
   int          rise_n = 0;              // serial rises since trigger
   sca_host host_u (.i_ref_clk, .o_serial_clk(ser_clk),
      .o_sample_trigger(trig));
   sca_core #(.RES(14)) dut_u (.i_ref_clk, .i_rst, .i_serial_clk(ser_clk),
      .i_sample_trigger(trig), .i_late_trigger, .i_sample_value,
      .o_serial_result_out(sro), .o_serial_result_oe_n(sro_oe_n),
      .o_acquiring(acq), .o_nap(nap), .o_sleep(slp));
   initial forever #5 i_ref_clk = ~i_ref_clk;
   task automatic check(string n, logic [15:0] e, logic [15:0] s);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // bits taken as the host would at each serial rise; the design has not
   // seen that rise yet, so the previous bit is still standing
   always @(negedge i_ref_clk) begin
      ser_last <= ser_clk;
      if ($rose(trig)) rise_n <= 0;
      else if (ser_clk && !ser_last) rise_n <= rise_n + 1;
      if (ser_clk && !ser_last && sro_oe_n === 1'b0) sh <= {sh[14:0], sro};
      // drive must begin at the first rise, or the second when late
      if ($fell(sro_oe_n) && !i_rst)
         check("lead", 16'(i_late_trigger) + 16'h0001, 16'(rise_n));
      if ($rose(sro_oe_n) && !i_rst) check("word", exp_q.pop_front(), sh);
   end
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 6000) begin
         failures++;
         finish_test();
      end
   end
   initial begin
      int unsigned v;
      v = $urandom(32'h444e);
      repeat (12) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      // frames with boundary and random values, prompt and slow clock
      for (int k = 0; k < 9; k++) begin
         v = (k == 1) ? 32'h3FFF : (k == 0) ? 0 : $urandom;
         if (k > 0) exp_q.push_back({2'b00, prev});
         i_sample_value <= v[13:0];
         i_late_trigger <= (k == 5);
         host_u.frame(k[0] ? 5 : 3);
         prev = v[13:0];
         check("acq", 16'h0001, 16'(acq));
      end
      repeat (10) @(posedge i_ref_clk);
      check("left", 16'h0000, 16'(exp_q.size()));
      // park the clock high: this rise finds no frame due, so none loads
      host_u.hold(1'b1);
      host_u.pulses(2);
      repeat (4) @(posedge i_ref_clk);
      check("nap", 16'h0001, {15'h0000, nap});
      host_u.hold(1'b0);
      repeat (4) @(posedge i_ref_clk);
      check("nap_end", 16'h0000, {15'h0000, nap});
      host_u.pulses(4);
      repeat (4) @(posedge i_ref_clk);
      check("sleep", 16'h0001, {15'h0000, slp});
      host_u.tick(3);
      repeat (4) @(posedge i_ref_clk);
      check("wake", 16'h0000, {15'h0000, slp});
      // no word is compared after wake while the reference settles
      finish_test();
   end
endmodule
bind sca_core sca_assertions chk_u (.i_ref_clk, .i_rst, .i_serial_clk,
   .i_sample_trigger, .o_serial_result_out, .o_serial_result_oe_n,
   .o_acquiring, .o_nap, .o_sleep);

// File: sca_host.sv
// host side: serial clock and trigger; clock stands still between frames
module sca_host (
   input  wire logic i_ref_clk,        // block clock
   output logic      o_serial_clk,     // host serial clock
   output logic      o_sample_trigger  // convert strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_serial_clk = 1'b0;
   initial o_sample_trigger = 1'b0;
   // one serial pulse, h cycles per phase; h sets prompt or slow pace
   task automatic tick(int h);
      repeat (h) @(posedge i_ref_clk);
      o_serial_clk <= 1'b1;
      repeat (h) @(posedge i_ref_clk);
      o_serial_clk <= 1'b0;
   endtask
   // trigger leads the first rise by over half a period; 18 rises leave
   // two spare rises of acquisition after the 16th
   task automatic frame(int h);
      @(posedge i_ref_clk);
      o_sample_trigger <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      o_sample_trigger <= 1'b0;
      repeat (18) tick(h);
   endtask
   // serial clock parked at one level, as around power-down pulses
   task automatic hold(logic b);
      @(posedge i_ref_clk);
      o_serial_clk <= b;
   endtask
   // trigger pulses with the serial clock held still
   task automatic pulses(int n);
      repeat (n) begin
         @(posedge i_ref_clk);
         o_sample_trigger <= 1'b1;
         repeat (2) @(posedge i_ref_clk);
         o_sample_trigger <= 1'b0;
         @(posedge i_ref_clk);
      end
   endtask
endmodule

// File: sca_pkg.sv
// Behaviour
// - trigger rise freezes input, starts conversion
// - each serial clock rise steps sequence, shifts; the late-trigger slip rise does neither
// - acquisition opens at 16th rise, closes trigger
// - late trigger delays whole word one cycle
// - word carries previous conversion's sampled input
// - output three-state when not presenting bits
// - two trigger pulses, clock still: nap
// - four or more pulses, clock still: sleep
// - any serial clock pulse wakes from sleep
// - resolution 14 bits or 12 bits
package sca_pkg;
   localparam int FRAME_LEN      = 16;   // clocks per readout frame
   localparam int ACQ_OPEN_EDGE  = 16;   // edge that opens acquisition
   localparam int LEAD_PAD       = 2;    // leading pad bits in frame
   localparam int NAP_PULSES     = 2;    // trigger pulses for nap
   localparam int SLEEP_PULSES   = 4;    // trigger pulses for sleep
   localparam int CNT_W          = 5;    // frame counter width
   localparam logic [4:0] CNT_IDLE = 5'h1F; // counter parked value
   localparam int CLK_PERIOD_NS  = 10;   // reference clock period
   localparam int ACQ_MIN_NS     = 45;   // minimum acquisition interval
   localparam int ACQ_MIN_CYC    =
      (ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic [1:0] {
      SCA_ACTIVE,
      SCA_NAP,
      SCA_SLEEP
   } sca_pwr_type;
endpackage
